//--- design/ttc_pkg.sv
// constants shared by the three-channel timer block
package ttc_pkg;
   // register map
   localparam logic [7:0] CH_STRIDE = 8'h40;
   localparam logic [5:0] OFF_CCR = 6'h00;
   localparam logic [5:0] OFF_MODE = 6'h04;
   localparam logic [5:0] OFF_CV = 6'h10;
   localparam logic [5:0] OFF_RA = 6'h14;
   localparam logic [5:0] OFF_RB = 6'h18;
   localparam logic [5:0] OFF_RC = 6'h1C;
   localparam logic [5:0] OFF_SR = 6'h20;
   localparam logic [5:0] OFF_IER = 6'h24;
   localparam logic [5:0] OFF_IDR = 6'h28;
   localparam logic [5:0] OFF_IMR = 6'h2C;
   localparam logic [7:0] OFF_BCR = 8'hC0;
   localparam logic [7:0] OFF_BMR = 8'hC4;
   // reset values
   localparam logic [31:0] MODE_RST = 32'h0000_0000;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [5:0] BMR_RST = 6'h00;
   // command bits
   localparam int CMD_CLK_ON = 0;
   localparam int CMD_CLK_OFF = 1;
   localparam int CMD_SWTRIG = 2;
   localparam int BCR_ALL_TRIG = 0;
   // channel_mode fields
   localparam int F_CLK_SEL = 0;
   localparam int F_EDGE_INV = 3;
   localparam int F_GATE = 4;
   localparam int F_STOP_B = 6;
   localparam int F_DIS_B = 7;
   localparam int F_TRG_EDGE = 8;
   localparam int F_TRG_LINE = 10;
   localparam int F_EV_SRC = 10;
   localparam int F_EV_TRG = 12;
   localparam int F_SHAPE = 13;
   localparam int F_CMATCH_TRG = 14;
   localparam int F_WAVE = 15;
   localparam int F_LOAD_A = 16;
   localparam int F_LOAD_B = 18;
   localparam int F_A_ON_A = 16;
   localparam int F_A_ON_C = 18;
   localparam int F_A_ON_EV = 20;
   localparam int F_A_ON_SW = 22;
   localparam int F_B_ON_B = 24;
   localparam int F_B_ON_C = 26;
   localparam int F_B_ON_EV = 28;
   localparam int F_B_ON_SW = 30;
   // status bits
   localparam int SR_OVF = 0;
   localparam int SR_LOVR = 1;
   localparam int SR_CPA = 2;
   localparam int SR_CPB = 3;
   localparam int SR_CPC = 4;
   localparam int SR_LDA = 5;
   localparam int SR_LDB = 6;
   localparam int SR_ETRG = 7;
   localparam int SR_CLKSTA = 16;
   localparam int SR_LINE_A = 17;
   localparam int SR_LINE_B = 18;
   localparam logic [7:0] SR_STICKY_MASK = 8'hFF;
   // internal clock prescale ratios for internal_clock_1..5
   localparam int unsigned DIV1 = 2;
   localparam int unsigned DIV2 = 8;
   localparam int unsigned DIV3 = 32;
   localparam int unsigned DIV4 = 128;
   localparam int unsigned DIV5 = 1024;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
endpackage : ttc_pkg

//--- design/ttc_timer.sv
// three-channel 16-bit timer/counter with apb register access
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
module ttc_timer (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [2:0] clock_pin,
   input wire logic [2:0] io_line_a_in,
   output logic [2:0] io_line_a_out,
   output logic [2:0] io_line_a_oe,
   input wire logic [2:0] io_line_b_in,
   output logic [2:0] io_line_b_out,
   output logic [2:0] io_line_b_oe,
   output logic [2:0] irq_line
);
   // two-flop synchronisers for all pins
   logic [2:0] clk_m, clk_s, ioa_m, ioa_s, iob_m, iob_s;
   logic [2:0] ioa_d, iob_d, ext_d; // previous synced values for edge detect
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         clk_m <= 3'h0;
         clk_s <= 3'h0;
         ioa_m <= 3'h0;
         ioa_s <= 3'h0;
         iob_m <= 3'h0;
         iob_s <= 3'h0;
      end else begin
         clk_m <= clock_pin;
         clk_s <= clk_m;
         ioa_m <= io_line_a_in;
         ioa_s <= ioa_m;
         iob_m <= io_line_b_in;
         iob_s <= iob_m;
      end
   end

   // line a level seen by others: driven value in waveform mode, pin in capture
   logic [2:0] line_a, line_b;
   logic [31:0] mode [3];
   logic [5:0] bmr;
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         line_a[i] = mode[i][ttc_pkg::F_WAVE] ? io_line_a_out[i] : ioa_s[i];
         line_b[i] = io_line_b_oe[i] ? io_line_b_out[i] : iob_s[i];
      end
   end

   // external clock routing
   logic [2:0] ext_clk;
   always_comb begin
      case (bmr[1:0])
         2'h0: ext_clk[0] = clk_s[0];
         2'h2: ext_clk[0] = line_a[1];
         2'h3: ext_clk[0] = line_a[2];
         default: ext_clk[0] = 1'b0;
      endcase
      case (bmr[3:2])
         2'h0: ext_clk[1] = clk_s[1];
         2'h2: ext_clk[1] = line_a[0];
         2'h3: ext_clk[1] = line_a[2];
         default: ext_clk[1] = 1'b0;
      endcase
      case (bmr[5:4])
         2'h0: ext_clk[2] = clk_s[2];
         2'h2: ext_clk[2] = line_a[0];
         2'h3: ext_clk[2] = line_a[1];
         default: ext_clk[2] = 1'b0;
      endcase
   end

   // prescaler: internal clocks are square waves toggled from one counter
   logic [9:0] pre;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) pre <= 10'h000;
      else pre <= pre + 10'h001;
   end
   logic [4:0] int_clk;
   assign int_clk = {pre[9], pre[6], pre[4], pre[2], pre[0]};

   // edge selector shared by loads, triggers and events
   function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic was);
      case (sel)
         2'h1: edge_hit = now & ~was;
         2'h2: edge_hit = ~now & was;
         2'h3: edge_hit = now ^ was;
         default: edge_hit = 1'b0;
      endcase
   endfunction : edge_hit

   // output action: none, set, clear, toggle
   function automatic logic act(input logic [1:0] sel, input logic cur);
      case (sel)
         2'h1: act = 1'b1;
         2'h2: act = 1'b0;
         2'h3: act = ~cur;
         default: act = cur;
      endcase
   endfunction : act

   // apb decode, single-cycle answer
   logic wr, rd;
   logic [1:0] ch_idx;
   logic [5:0] ch_off;
   logic ch_hit;
   assign pready = 1'b1;
   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;
   assign ch_idx = paddr[7:6];
   assign ch_off = paddr[5:0];
   assign ch_hit = (ch_idx != 2'h3);
   logic all_trig;
   assign all_trig = wr && paddr == ttc_pkg::OFF_BCR && pwdata[ttc_pkg::BCR_ALL_TRIG];

   // block mode register
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) bmr <= ttc_pkg::BMR_RST;
      else if (wr && paddr == ttc_pkg::OFF_BMR) bmr <= pwdata[5:0];
   end

   // per-channel state
   logic [15:0] cnt [3];
   logic [15:0] ra [3];
   logic [15:0] rb [3];
   logic [15:0] rc [3];
   logic [7:0] sr [3];
   logic [7:0] imr [3];
   logic [2:0] clk_en, going_down, a_done, src_d;
   logic [2:0] out_a, out_b;
   logic [2:0] cmd_wr;

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         cmd_wr[i] = wr && ch_hit && ch_idx == 2'(i);
         io_line_a_out[i] = out_a[i];
         io_line_b_out[i] = out_b[i];
         io_line_a_oe[i] = mode[i][ttc_pkg::F_WAVE];
         // line b turns input when it is the event source
         io_line_b_oe[i] = mode[i][ttc_pkg::F_WAVE] &&
                           mode[i][ttc_pkg::F_EV_SRC +: 2] != 2'h0;
         irq_line[i] = |(sr[i] & imr[i]);
      end
   end

   // count source sampling, held per channel
   logic [2:0] src_now;
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         logic s;
         logic [2:0] cs;
         logic [1:0] g;
         cs = mode[i][ttc_pkg::F_CLK_SEL +: 3];
         g = mode[i][ttc_pkg::F_GATE +: 2];
         s = cs[2] && cs != 3'h4 ? ext_clk[cs[1:0] - 2'h1] : int_clk[cs];
         if (g != 2'h0) s = s & ext_clk[g - 2'h1];
         src_now[i] = s ^ mode[i][ttc_pkg::F_EDGE_INV];
      end
   end

   // channel engine
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < 3; i++) begin
            mode[i] <= ttc_pkg::MODE_RST;
            cnt[i] <= ttc_pkg::CNT_RST;
            ra[i] <= ttc_pkg::CNT_RST;
            rb[i] <= ttc_pkg::CNT_RST;
            rc[i] <= ttc_pkg::CNT_RST;
            sr[i] <= 8'h00;
            imr[i] <= 8'h00;
         end
         clk_en <= 3'h0;
         going_down <= 3'h0;
         a_done <= 3'h0;
         src_d <= 3'h0;
         out_a <= 3'h0;
         out_b <= 3'h0;
         ioa_d <= 3'h0;
         iob_d <= 3'h0;
         ext_d <= 3'h0;
      end else begin
         ioa_d <= line_a;
         iob_d <= line_b;
         ext_d <= ext_clk;
         src_d <= src_now;
         for (int i = 0; i < 3; i++) begin
            logic wave, tick, sw, trg, ev, ld_a, ld_b, cm_a, cm_b, cm_c, stop;
            logic [31:0] m;
            logic [7:0] set;
            logic [1:0] es;
            m = mode[i];
            wave = m[ttc_pkg::F_WAVE];
            tick = src_now[i] & ~src_d[i];
            set = 8'h00;
            stop = 1'b0;
            sw = (cmd_wr[i] && ch_off == ttc_pkg::OFF_CCR &&
                  pwdata[ttc_pkg::CMD_SWTRIG]) || all_trig;
            cm_a = cnt[i] == ra[i] && clk_en[i]; // a stopped counter makes no compares
            cm_b = cnt[i] == rb[i] && clk_en[i];
            cm_c = cnt[i] == rc[i] && clk_en[i];
            ld_a = 1'b0;
            ld_b = 1'b0;
            ev = 1'b0;
            trg = 1'b0;
            if (!wave) begin
               // capture: trigger from a or b line
               ev = m[ttc_pkg::F_TRG_LINE] ?
                    edge_hit(m[ttc_pkg::F_TRG_EDGE +: 2], line_a[i], ioa_d[i]) :
                    edge_hit(m[ttc_pkg::F_TRG_EDGE +: 2], line_b[i], iob_d[i]);
               trg = ev || (tick && cm_c && m[ttc_pkg::F_CMATCH_TRG]);
               // a then b alternate loading from line a
               ld_a = !a_done[i] &&
                      edge_hit(m[ttc_pkg::F_LOAD_A +: 2], line_a[i], ioa_d[i]);
               ld_b = a_done[i] &&
                      edge_hit(m[ttc_pkg::F_LOAD_B +: 2], line_a[i], ioa_d[i]);
               if (ld_a) begin
                  ra[i] <= cnt[i];
                  a_done[i] <= 1'b1;
                  set[ttc_pkg::SR_LDA] = 1'b1;
               end
               if (ld_b) begin
                  rb[i] <= cnt[i];
                  a_done[i] <= 1'b0;
                  set[ttc_pkg::SR_LDB] = 1'b1;
                  stop = m[ttc_pkg::F_STOP_B] | m[ttc_pkg::F_DIS_B];
               end
            end else begin
               es = m[ttc_pkg::F_EV_SRC +: 2];
               ev = es == 2'h0 ?
                    edge_hit(m[ttc_pkg::F_TRG_EDGE +: 2], line_b[i], iob_d[i]) :
                    edge_hit(m[ttc_pkg::F_TRG_EDGE +: 2], ext_clk[es - 2'h1],
                             ext_d[es - 2'h1]);
               trg = (ev && m[ttc_pkg::F_EV_TRG]) ||
                     (tick && cm_c && m[ttc_pkg::F_SHAPE + 1] && !m[ttc_pkg::F_SHAPE]);
               if (tick && cm_c)
                  stop = m[ttc_pkg::F_STOP_B] | m[ttc_pkg::F_DIS_B];
               // output controller, software trigger takes priority
               if (sw) begin
                  out_a[i] <= act(m[ttc_pkg::F_A_ON_SW +: 2], out_a[i]);
                  out_b[i] <= act(m[ttc_pkg::F_B_ON_SW +: 2], out_b[i]);
               end else if (ev) begin
                  out_a[i] <= act(m[ttc_pkg::F_A_ON_EV +: 2], out_a[i]);
                  out_b[i] <= act(m[ttc_pkg::F_B_ON_EV +: 2], out_b[i]);
               end else if (tick && cm_c) begin
                  out_a[i] <= act(m[ttc_pkg::F_A_ON_C +: 2], out_a[i]);
                  out_b[i] <= act(m[ttc_pkg::F_B_ON_C +: 2], out_b[i]);
               end else if (tick) begin
                  if (cm_a) out_a[i] <= act(m[ttc_pkg::F_A_ON_A +: 2], out_a[i]);
                  if (cm_b) out_b[i] <= act(m[ttc_pkg::F_B_ON_B +: 2], out_b[i]);
               end
               if (tick) begin
                  set[ttc_pkg::SR_CPA] = cm_a;
                  set[ttc_pkg::SR_CPB] = cm_b;
               end
            end
            if (tick && cm_c) set[ttc_pkg::SR_CPC] = 1'b1;
            if (ev) set[ttc_pkg::SR_ETRG] = 1'b1;
            // counter clock enable
            if (cmd_wr[i] && ch_off == ttc_pkg::OFF_CCR && pwdata[ttc_pkg::CMD_CLK_OFF])
               clk_en[i] <= 1'b0;
            else if (stop)
               clk_en[i] <= 1'b0;
            else if ((cmd_wr[i] && ch_off == ttc_pkg::OFF_CCR &&
                      pwdata[ttc_pkg::CMD_CLK_ON]) || sw || trg)
               clk_en[i] <= 1'b1;
            // counting; triggers reset or reverse
            if (sw || trg) begin
               if (wave && m[ttc_pkg::F_SHAPE]) going_down[i] <= ~going_down[i];
               else cnt[i] <= ttc_pkg::CNT_RST;
               if (!wave) a_done[i] <= 1'b0;
            end else if (tick && clk_en[i]) begin
               if (wave && m[ttc_pkg::F_SHAPE]) begin
                  if (going_down[i]) begin
                     if (cnt[i] == 16'h0001) going_down[i] <= 1'b0;
                     cnt[i] <= cnt[i] - 16'h0001;
                  end else begin
                     if (cnt[i] + 16'h0001 == (m[ttc_pkg::F_SHAPE + 1] ? rc[i] :
                         ttc_pkg::CNT_MAX)) going_down[i] <= 1'b1;
                     cnt[i] <= cnt[i] + 16'h0001;
                  end
               end else begin
                  if (cnt[i] == ttc_pkg::CNT_MAX) set[ttc_pkg::SR_OVF] = 1'b1;
                  cnt[i] <= cnt[i] + 16'h0001;
               end
            end
            // status: cleared on read, a new event wins over the clear
            if (rd && ch_hit && ch_idx == 2'(i) && ch_off == ttc_pkg::OFF_SR)
               sr[i] <= set;
            else
               sr[i] <= sr[i] | set;
            // register writes
            if (cmd_wr[i]) begin
               case (ch_off)
                  ttc_pkg::OFF_MODE: mode[i] <= pwdata;
                  ttc_pkg::OFF_RA: if (wave) ra[i] <= pwdata[15:0];
                  ttc_pkg::OFF_RB: if (wave) rb[i] <= pwdata[15:0];
                  ttc_pkg::OFF_RC: rc[i] <= pwdata[15:0];
                  ttc_pkg::OFF_IER: imr[i] <= imr[i] | pwdata[7:0];
                  ttc_pkg::OFF_IDR: imr[i] <= imr[i] & ~pwdata[7:0];
                  default: ;
               endcase
            end
         end
      end
   end

   // read mux; write-only and unmapped read as zero
   always_comb begin
      prdata = 32'h0000_0000;
      pslverr = 1'b0;
      if (rd) begin
         if (paddr == ttc_pkg::OFF_BMR) prdata = {26'h0, bmr};
         else if (ch_hit) begin
            case (ch_off)
               ttc_pkg::OFF_MODE: prdata = mode[ch_idx];
               ttc_pkg::OFF_CV: prdata = {16'h0, cnt[ch_idx]};
               ttc_pkg::OFF_RA: prdata = {16'h0, ra[ch_idx]};
               ttc_pkg::OFF_RB: prdata = {16'h0, rb[ch_idx]};
               ttc_pkg::OFF_RC: prdata = {16'h0, rc[ch_idx]};
               ttc_pkg::OFF_SR: prdata = {13'h0, line_b[ch_idx], line_a[ch_idx],
                                          clk_en[ch_idx], 8'h00, sr[ch_idx]};
               ttc_pkg::OFF_IMR: prdata = {24'h0, imr[ch_idx]};
               default: prdata = 32'h0000_0000;
            endcase
         end
      end
   end

   // apb never stalls, so any access finishes in its first access cycle
   bus_done_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      psel && penable |-> pready) else $error("apb access stalled");
   // software trigger from block write zeroes the channel 0 counter in capture mode and turns its clock on
   trig_zero_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      all_trig && !mode[0][ttc_pkg::F_WAVE] |=> cnt[0] == 16'h0000 && clk_en[0])
      else $error("block trigger missed channel 0");
   // capture-mode compare a takes no bus write; no line a edge, so no load either
   ra_ro_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      cmd_wr[0] && ch_off == ttc_pkg::OFF_RA && !mode[0][ttc_pkg::F_WAVE]
      && line_a[0] == ioa_d[0] |=> $stable(ra[0])) else $error("compare a overwritten");
   // off command wins over on command
   clk_off_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      cmd_wr[2] && ch_off == ttc_pkg::OFF_CCR && pwdata[ttc_pkg::CMD_CLK_OFF]
      |=> !clk_en[2]) else $error("clock off ignored");
   // clean enable command turns clock on
   clk_on_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      cmd_wr[2] && ch_off == ttc_pkg::OFF_CCR && pwdata[2:0] == 3'h1 |=> clk_en[2])
      else $error("clock on ignored");
   // mask bits follow enable writes
   mask_set_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      cmd_wr[0] && ch_off == ttc_pkg::OFF_IER |=> (imr[0] & $past(pwdata[7:0]))
      == $past(pwdata[7:0])) else $error("mask not set");
   // line b stays undriven when it is the event source
   line_b_in_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      mode[0][ttc_pkg::F_EV_SRC +: 2] == 2'h0 |-> !io_line_b_oe[0])
      else $error("line b driven as event input");
   // b load with stop bit set halts the clock
   stop_b_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      $rose(sr[0][ttc_pkg::SR_LDB]) && mode[0][ttc_pkg::F_STOP_B] &&
      !mode[0][ttc_pkg::F_WAVE] && !sr[0][ttc_pkg::SR_ETRG] |-> !clk_en[0])
      else $error("b load did not stop clock");
endmodule : ttc_timer

//--- bench/ttc_pin_model.sv
// pin-side model: resolves the shared io lines and drives the clock pins
`timescale 1ns/1ns
module ttc_pin_model (
   input wire logic [2:0] a_out,
   input wire logic [2:0] a_oe,
   input wire logic [2:0] b_out,
   input wire logic [2:0] b_oe,
   input wire logic [2:0] clk_drv,
   input wire logic [2:0] a_drv,
   input wire logic [2:0] b_drv,
   output logic [2:0] clock_pin,
   output logic [2:0] a_in,
   output logic [2:0] b_in
);
   // the timer wins a line while it enables it, otherwise the outside source does
   assign a_in = (a_oe & a_out) | (~a_oe & a_drv);
   assign b_in = (b_oe & b_out) | (~b_oe & b_drv);
   // clock pins are plain inputs to the block
   assign clock_pin = clk_drv;
endmodule : ttc_pin_model

//--- bench/testbench.sv
// self-checking bench for the three-channel timer register block
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
$display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module testbench;
   logic ref_clk = 1'b0; // 100 MHz
   logic arst_n = 1'b0; // held low for 12 cycles
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [2:0] clock_pin, a_in, a_out, a_oe, b_in, b_out, b_oe, irq_line;
   logic [2:0] clk_drv = 3'h0; // outside sources on the pins
   logic [2:0] a_drv = 3'h0;
   logic [2:0] b_drv = 3'h0; // line b stays low: no trigger from it
   int fail_count = 0;
   int cmp_count = 0;
   logic [31:0] d, d2;
   logic [7:0] roff [9] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h2C};
   logic [2:0] cmds [6] = '{3'h1, 3'h3, 3'h3, 3'h1, 3'h0, 3'h2};
   logic onx [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
   int src_of [4] = '{0, 0, 1, 2};
   // free-running clock
   always #5 ref_clk = ~ref_clk;
   ttc_timer ttc_timer_i (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .clock_pin(clock_pin), .io_line_a_in(a_in), .io_line_a_out(a_out),
      .io_line_a_oe(a_oe), .io_line_b_in(b_in), .io_line_b_out(b_out), .io_line_b_oe(b_oe),
      .irq_line(irq_line));
   ttc_pin_model ttc_pin_model_i (.a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
      .clk_drv(clk_drv), .a_drv(a_drv), .b_drv(b_drv), .clock_pin(clock_pin), .a_in(a_in),
      .b_in(b_in));
   // one apb transfer; the answer is awaited, never assumed
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      `CHK(pslverr, 1'b0)
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] x;
      xfer(1'b1, a, wd, x);
   endtask : wr
   task rd(input logic [7:0] a, output logic [31:0] v);
      xfer(1'b0, a, 32'h0000_0000, v);
   endtask : rd
   task chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      rd(a, v);
      `CHK(v, e)
   endtask : chk
   // moves one count source: 0 clock pin 0, 1 and 2 line a of channel 1 and 2
   task drive_src(input int s, input logic v);
      @(posedge ref_clk);
      if (s == 0) clk_drv[0] <= v;
      else a_drv[s] <= v;
      repeat (4) @(posedge ref_clk);
   endtask : drive_src
   task done(input string n);
      $display("test %s done", n);
   endtask : done
   // verdict; also reached from the watchdog
   task results;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results
   // watchdog: the sequence needs under a thousand cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      results();
   end
   // main sequence
   initial begin
      repeat (12) @(posedge ref_clk);
      arst_n <= 1'b1;
      for (int c = 0; c < 3; c++) foreach (roff[i]) chk(8'(c * 64) + roff[i], 32'h0);
      chk(8'hC4, 32'h0);
      `CHK(irq_line, 3'h0)
      done("reset");
      wr(8'h04, 32'h000F_47FF);
      wr(8'h44, 32'h0000_0005);
      chk(8'h04, 32'h000F_47FF);
      chk(8'h44, 32'h0000_0005);
      chk(8'h84, 32'h0);
      wr(8'h44, 32'h0);
      wr(8'h04, 32'h0);
      wr(8'h14, 32'h0000_1234);
      chk(8'h14, 32'h0);
      // waveform: soft trigger sets, clears, toggles line a
      wr(8'h04, 32'h4040_8400);
      wr(8'h14, 32'h0000_1234);
      chk(8'h14, 32'h0000_1234);
      wr(8'h00, 32'h4);
      repeat (3) @(posedge ref_clk);
      `CHK(a_out[0], 1'b1)
      `CHK(a_oe[0], 1'b1)
      `CHK(b_oe[0], 1'b1)
      `CHK(b_out[0], 1'b1)
      wr(8'h04, 32'h0080_8000);
      wr(8'h00, 32'h4);
      repeat (3) @(posedge ref_clk);
      `CHK(a_out[0], 1'b0)
      `CHK(b_oe[0], 1'b0)
      wr(8'h04, 32'h00C0_8000);
      wr(8'h00, 32'h4);
      repeat (3) @(posedge ref_clk);
      `CHK(a_out[0], 1'b1)
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h2);
      done("modes");
      // clock on and off commands on channel 2
      for (int i = 0; i < 6; i++) begin
         wr(8'h80, {29'h0, cmds[i]});
         rd(8'hA0, d);
         `CHK(d[16], onx[i])
      end
      wr(8'hC0, 32'h0);
      for (int c = 0; c < 3; c++) begin
         rd(8'(c * 64) + 8'h20, d);
         `CHK(d[16], 1'b0)
      end
      wr(8'hC0, 32'h1);
      for (int c = 0; c < 3; c++) begin
         rd(8'(c * 64) + 8'h20, d);
         `CHK(d[16], 1'b1)
         wr(8'(c * 64), 32'h2);
      end
      wr(8'h24, 32'h15);
      chk(8'h2C, 32'h15);
      wr(8'h28, 32'h05);
      wr(8'h24, 32'h00);
      chk(8'h2C, 32'h10);
      wr(8'h28, 32'h10);
      done("commands");
      // ext clock 0 routing, counted by channel 0; configured before start
      wr(8'h04, 32'h5);
      for (int k = 0; k < 4; k++) begin
         wr(8'hC4, 32'(k));
         wr(8'h00, 32'h5);
         repeat (3) begin
            drive_src(src_of[k], 1'b1);
            drive_src(src_of[k], 1'b0);
         end
         chk(8'h10, (k == 1) ? 32'h0 : 32'h3);
      end
      wr(8'hC4, 32'h0);
      for (int i = 0; i < 2; i++) begin
         wr(8'h04, 32'h5 | 32'(i << 3));
         drive_src(0, 1'b1);
         wr(8'h00, 32'h5);
         drive_src(0, 1'b0);
         chk(8'h10, 32'(i));
      end
      // internal clock gated by clock pin 0
      wr(8'h04, 32'h10);
      wr(8'h00, 32'h5);
      repeat (30) @(posedge ref_clk);
      chk(8'h10, 32'h0);
      drive_src(0, 1'b1);
      repeat (20) @(posedge ref_clk);
      rd(8'h10, d);
      `CHK(d != 32'h0, 1'b1)
      drive_src(0, 1'b0);
      done("clocks");
      // capture: a on rising, b on falling, stop on b load
      wr(8'h24, 32'h20);
      wr(8'h04, 32'h0009_0040);
      wr(8'h00, 32'h5);
      repeat (20) @(posedge ref_clk);
      a_drv[0] <= 1'b1;
      repeat (20) @(posedge ref_clk);
      a_drv[0] <= 1'b0;
      repeat (10) @(posedge ref_clk);
      `CHK(irq_line[0], 1'b1)
      rd(8'h14, d);
      rd(8'h18, d2);
      `CHK(d != 32'h0, 1'b1)
      `CHK(d2 > d, 1'b1)
      rd(8'h20, d);
      `CHK(d[16], 1'b0)
      `CHK(d[6:5], 2'b11)
      rd(8'h10, d);
      `CHK(irq_line[0], 1'b0)
      repeat (10) @(posedge ref_clk);
      chk(8'h10, d);
      wr(8'h00, 32'h4);
      rd(8'h10, d);
      `CHK(d < 32'h8, 1'b1)
      done("capture");
      results();
   end
endmodule : testbench
